// ===== hw/vectored_interrupt_priority_ctrl.sv
// vectored interrupt controller with APB register slave and CPU level tracking
// How it works
// (RULE_01) pwm one period match sets request 57, vector table slot 0x86/0x186
// (RULE_02) position counter compare sets request 58, vector 66, slot 0x88/0x188
// (RULE_03) pwm one fault A sets request 63, vector 71, slot 0x92/0x192
// (RULE_04) pwm two period match sets request 73, vector 81, slot 0xA6/0x1A6
// (RULE_05) pwm two fault A sets request 74, vector 82, slot 0xA8/0x1A8
// (RULE_06) twenty-two software visible registers in the map
// (RULE_07) each source has a flag set by hardware, cleared only by software
// (RULE_08) a disabled source is never presented, though its flag still sets
// (RULE_09) each source has a three bit priority, eight levels
// (RULE_10) winning vector number and level latch into the pending vector register
// (RULE_11) flag, enable and priority fields sit in request number order
// (RULE_12) status word bits 7:5 hold low cpu level, writable by software
// (RULE_13) core control bit 3 holds level bit three, read only
// (RULE_14) cpu level is bit three above status bits; bit three set blocks all
// (RULE_15) level field 111 means level 7 or 15, no user interrupt taken
// (RULE_16) nesting disable makes the status level bits read only
// (RULE_17) level bit three reads 1 above 7, 0 otherwise, resets 0
// (RULE_18) control reg one holds nesting and trap bits, two holds pins and table
// (RULE_19) nesting disable 1 stops nesting, 0 allows it, resets 0
// (RULE_20) alternate table select 1 uses the alternate table base
// (RULE_21) external pin edge polarity 1 falling, 0 rising
// (RULE_22) presented only above cpu level; equal priority, lower number wins
// (RULE_23) vector is request plus eight; address is base plus twice vector
`include "vic_params.svh"
module vectored_interrupt_priority_ctrl
   import vic_pkg::*;
#(
   parameter int NUM_IRQ = 75,
   parameter int ADDR_W  = 8
) (
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [NUM_IRQ-1:0] periphEvent,
   input  wire logic [2:0]        extPin,
   input  wire logic              pwmOnePeriod,
   input  wire logic              qeiCompare,
   input  wire logic              pwmOneFault,
   input  wire logic              pwmTwoPeriod,
   input  wire logic              pwmTwoFault,
   input  wire trap_t             trapEvent,
   input  wire logic              trapReturn,
   input  wire logic              cpuAck,
   input  wire logic              cpuReturn,
   input  wire logic [2:0]        returnLevel,
   output irq_present_t           present,
   output logic      [3:0]        cpuLevel
);
   localparam int FLAG_REGS = (NUM_IRQ + 31) / 32;
   localparam int PRIO_REGS = (NUM_IRQ + 7) / 8;
   localparam int FLAG_W    = FLAG_REGS * 32;
   localparam int PRIO_W    = PRIO_REGS * 32;
   localparam logic [7:0] OFS_F = `OFS_FLAG0;
   localparam logic [7:0] OFS_E = `OFS_ENABLE0;
   localparam logic [7:0] OFS_P = `OFS_PRIO0;
   localparam logic [7:0] OFS_C1 = `OFS_CTRL_ONE;
   localparam logic [7:0] OFS_C2 = `OFS_CTRL_TWO;
   localparam logic [7:0] OFS_PV = `OFS_PEND_VEC;
   localparam logic [7:0] OFS_SR = `OFS_STATUS;
   localparam logic [7:0] OFS_CC = `OFS_CORE;
   localparam logic [7:0] OFS_VA = `OFS_VEC_ADDR;

   function automatic logic inGroup(input logic [5:0] w, input logic [5:0] b,
                                    input logic [5:0] n);
      logic [5:0] d;
      d = w - b;
      return (w >= b) && (d < n);
   endfunction

   logic [FLAG_W-1:0] flag;
   logic [FLAG_W-1:0] enable;
   logic [2:0]        prio [NUM_IRQ];
   logic [PRIO_W-1:0] prioFlat;
   logic              nestingDisable;
   logic [3:0]        trapFlags;
   logic              altSelect;
   logic [2:0]        edgePolarity;
   logic [2:0]        extPrev;
   logic [2:0]        cpu_priority_level;
   logic              iplBitThree;
   logic [6:0]        pendVector;
   logic [3:0]        pendLevel;
   logic [31:0]       next_prdata;
   logic              next_pslverr;
   irq_present_t      next_present;
   logic [NUM_IRQ-1:0] namedEvt;
   logic              winFound;
   logic [6:0]        winIdx;
   logic [2:0]        winPrio;

   // bus decode
   wire logic [5:0] word     = paddr[7:2];
   wire logic       setup    = psel & ~penable;
   wire logic       access   = psel & penable & pready;
   wire logic       wr       = access & pwrite;
   wire logic       hitFlag  = inGroup(word, OFS_F[7:2], 6'(FLAG_REGS));
   wire logic       hitEn    = inGroup(word, OFS_E[7:2], 6'(FLAG_REGS));
   wire logic       hitPrio  = inGroup(word, OFS_P[7:2], 6'(PRIO_REGS));
   wire logic [5:0] fIdx     = word - OFS_F[7:2];
   wire logic [5:0] eIdx     = word - OFS_E[7:2];
   wire logic [5:0] pIdx     = word - OFS_P[7:2];
   wire logic       hitC1    = (word == OFS_C1[7:2]);
   wire logic       hitC2    = (word == OFS_C2[7:2]);
   wire logic       hitPv    = (word == OFS_PV[7:2]);
   wire logic       hitSr    = (word == OFS_SR[7:2]);
   wire logic       hitCc    = (word == OFS_CC[7:2]);
   wire logic       hitVa    = (word == OFS_VA[7:2]);
   wire logic       anyHit   = hitFlag | hitEn | hitPrio | hitC1 | hitC2 | hitPv |
                               hitSr | hitCc | hitVa; // RULE_06
   wire logic       wrC1     = wr & hitC1;
   wire logic       wrC2     = wr & hitC2;
   wire logic       wrSr     = wr & hitSr;
   wire logic       trapAny  = |trapEvent;

   // external pin edges
   wire logic [2:0] extEdge  = (edgePolarity & extPrev & ~extPin) |
                               (~edgePolarity & ~extPrev & extPin); // RULE_21

   always_comb begin
      namedEvt = '0;
      namedEvt[`IRQ_EXT0]     = extEdge[0];
      namedEvt[`IRQ_EXT1]     = extEdge[1];
      namedEvt[`IRQ_EXT2]     = extEdge[2];
      namedEvt[`IRQ_MOTOR_PWM_UNIT_ONE_PER] = pwmOnePeriod; // RULE_01
      namedEvt[`IRQ_QEI_CMP]  = qeiCompare; // RULE_02
      namedEvt[`IRQ_MOTOR_PWM_UNIT_ONE_FLT] = pwmOneFault; // RULE_03
      namedEvt[`IRQ_MOTOR_PWM_UNIT_TWO_PER] = pwmTwoPeriod; // RULE_04
      namedEvt[`IRQ_MOTOR_PWM_UNIT_TWO_FLT] = pwmTwoFault; // RULE_05
   end

   wire logic [NUM_IRQ-1:0] evt = periphEvent | namedEvt;

   // per-source state, bit i of the packed group belongs to request i
   genvar gi;
   generate
      for (gi = 0; gi < FLAG_W; gi++) begin : g_src
         if (gi < NUM_IRQ) begin : g_live
            wire logic fw = wr & hitFlag & (fIdx == 6'(gi / 32)); // RULE_11
            wire logic ew = wr & hitEn & (eIdx == 6'(gi / 32));
            // a hardware event in the clearing cycle survives the write
            always_ff @(posedge clk) begin
               if (srst) begin
                  flag[gi] <= 1'b0;
               end else begin
                  flag[gi] <= (fw ? pwdata[gi % 32] : flag[gi]) | evt[gi]; // RULE_07
               end
            end
            always_ff @(posedge clk) begin
               if (srst) begin
                  enable[gi] <= 1'b0;
               end else if (ew) begin
                  enable[gi] <= pwdata[gi % 32];
               end
            end
         end else begin : g_pad
            assign flag[gi]   = 1'b0;
            assign enable[gi] = 1'b0;
         end
      end
      for (gi = 0; gi < PRIO_REGS * 8; gi++) begin : g_pri
         if (gi < NUM_IRQ) begin : g_live
            wire logic pw = wr & hitPrio & (pIdx == 6'(gi / 8));
            always_ff @(posedge clk) begin
               if (srst) begin
                  prio[gi] <= `RST_PRIO;
               end else if (pw) begin
                  prio[gi] <= pwdata[(gi % 8) * 4 +: 3]; // RULE_09
               end
            end
            assign prioFlat[gi * 4 +: 4] = {1'b0, prio[gi]};
         end else begin : g_pad
            assign prioFlat[gi * 4 +: 4] = 4'h0;
         end
      end
   endgenerate

   // global control words
   always_ff @(posedge clk) begin
      if (srst) begin
         nestingDisable <= 1'b0;
         trapFlags      <= 4'h0;
      end else begin
         nestingDisable <= wrC1 ? pwdata[`POS_NEST] : nestingDisable; // RULE_19
         trapFlags <= (wrC1 ? pwdata[`POS_TRAP_LO +: 4] : trapFlags) | trapEvent; // RULE_18
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         altSelect    <= 1'b0;
         edgePolarity <= 3'h0;
      end else if (wrC2) begin
         altSelect    <= pwdata[`POS_ALT]; // RULE_18
         edgePolarity <= pwdata[2:0];
      end
   end

   // pin history is plain data; reset state is irrelevant once sampled
   always_ff @(posedge clk) begin
      extPrev <= extPin;
   end

   // cpu priority level
   always_ff @(posedge clk) begin
      if (srst) begin
         cpu_priority_level <= `RST_IPL;
      end else if (cpuAck) begin
         cpu_priority_level <= nestingDisable ? `IPL_MAX : present.level[2:0]; // RULE_19
      end else if (cpuReturn) begin
         cpu_priority_level <= returnLevel;
      end else if (wrSr && !nestingDisable) begin
         cpu_priority_level <= pwdata[`POS_IPL_LO +: 3]; // RULE_12 RULE_16
      end
   end

   // level bit three follows traps only; software has no write path
   always_ff @(posedge clk) begin
      if (srst) begin
         iplBitThree <= 1'b0; // RULE_17
      end else if (trapAny) begin
         iplBitThree <= 1'b1; // RULE_13
      end else if (trapReturn) begin
         iplBitThree <= 1'b0;
      end
   end

   wire logic [3:0] levelNow = {iplBitThree, cpu_priority_level}; // RULE_14

   // winner search; walking downward with >= leaves the lowest number on ties
   always_comb begin
      winFound = 1'b0;
      winIdx   = 7'h00;
      winPrio  = 3'h0;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (flag[i] && enable[i] && ({1'b0, prio[i]} > levelNow) && // RULE_08 RULE_15
             (!winFound || prio[i] >= winPrio)) begin // RULE_22
            winFound = 1'b1;
            winIdx   = 7'(i);
            winPrio  = prio[i];
         end
      end
   end

   wire logic [6:0]  winVector = winIdx + `VEC_OFFSET; // RULE_23
   wire logic [23:0] tableBase = altSelect ? `ALT_BASE : `PRI_BASE; // RULE_20

   always_comb begin
      next_present.valid  = winFound;
      next_present.vector = winVector;
      next_present.level  = {1'b0, winPrio};
      next_present.addr   = tableBase + {16'h0000, winVector, 1'b0}; // RULE_23
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         present  <= '0;
         cpuLevel <= 4'h0;
      end else begin
         present  <= next_present;
         cpuLevel <= levelNow;
      end
   end

   // pending vector register holds the last winner until a new one appears
   always_ff @(posedge clk) begin
      if (srst) begin
         pendVector <= 7'h00;
         pendLevel  <= 4'h0;
      end else if (winFound) begin
         pendVector <= winVector; // RULE_10
         pendLevel  <= {1'b0, winPrio};
      end
   end

   // read mux
   always_comb begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = !anyHit;
      if (hitFlag) begin
         next_prdata = flag[fIdx * 32 +: 32];
      end else if (hitEn) begin
         next_prdata = enable[eIdx * 32 +: 32];
      end else if (hitPrio) begin
         next_prdata = prioFlat[pIdx * 32 +: 32];
      end else if (hitC1) begin
         next_prdata[`POS_NEST]        = nestingDisable;
         next_prdata[`POS_TRAP_LO +: 4] = trapFlags;
      end else if (hitC2) begin
         next_prdata[`POS_ALT] = altSelect;
         next_prdata[2:0]      = edgePolarity;
      end else if (hitPv) begin
         next_prdata[6:0]             = pendVector;
         next_prdata[`POS_ILR_LO +: 4] = pendLevel;
      end else if (hitSr) begin
         next_prdata[`POS_IPL_LO +: 3] = cpu_priority_level;
      end else if (hitCc) begin
         next_prdata[`POS_CPU_PRIORITY_BIT_THREE] = iplBitThree; // RULE_13 RULE_17
      end else if (hitVa) begin
         next_prdata[23:0] = present.addr;
      end
   end

   // one wait-free access phase: data is ready at the edge closing setup
   always_ff @(posedge clk) begin
      if (srst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_pslverr;
         end
      end
   end

   // checks
   wire logic anyFlagWr = wr & hitFlag;

   AST_MOTOR_PWM_UNIT_ONE_PERIOD: assert property (@(posedge clk) disable iff (srst) // RULE_01
      pwmOnePeriod |=> flag[`IRQ_MOTOR_PWM_UNIT_ONE_PER])
      else $error("pwm one period did not set its flag");

   AST_QEI_COMPARE: assert property (@(posedge clk) disable iff (srst) // RULE_02
      qeiCompare |=> flag[`IRQ_QEI_CMP])
      else $error("position compare did not set its flag");

   AST_MOTOR_PWM_UNIT_ONE_FAULT: assert property (@(posedge clk) disable iff (srst) // RULE_03
      pwmOneFault |=> flag[`IRQ_MOTOR_PWM_UNIT_ONE_FLT])
      else $error("pwm one fault did not set its flag");

   AST_MOTOR_PWM_UNIT_TWO_PERIOD: assert property (@(posedge clk) disable iff (srst) // RULE_04
      pwmTwoPeriod |=> flag[`IRQ_MOTOR_PWM_UNIT_TWO_PER])
      else $error("pwm two period did not set its flag");

   AST_MOTOR_PWM_UNIT_TWO_FAULT: assert property (@(posedge clk) disable iff (srst) // RULE_05
      pwmTwoFault |=> flag[`IRQ_MOTOR_PWM_UNIT_TWO_FLT])
      else $error("pwm two fault did not set its flag");

   AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (srst) // RULE_07
      (flag[NUM_IRQ-1:0] != '0) && !anyFlagWr |=>
      ((flag[NUM_IRQ-1:0] & $past(flag[NUM_IRQ-1:0])) == $past(flag[NUM_IRQ-1:0])))
      else $error("a flag cleared without a software write");

   AST_DISABLED_HIDDEN: assert property (@(posedge clk) disable iff (srst) // RULE_08
      (enable == '0) |=> !present.valid)
      else $error("request presented with all enables clear");

   AST_BIT_THREE_BLOCKS: assert property (@(posedge clk) disable iff (srst) // RULE_14
      iplBitThree |=> !present.valid)
      else $error("user request presented while level bit three set");

   AST_STATUS_LOCKED: assert property (@(posedge clk) disable iff (srst) // RULE_16
      wrSr && nestingDisable && !cpuAck && !cpuReturn |=> cpu_priority_level == $past(cpu_priority_level))
      else $error("status level written while nesting disabled");

   AST_ABOVE_LEVEL: assert property (@(posedge clk) disable iff (srst) // RULE_22
      present.valid |-> present.level > $past(levelNow))
      else $error("request presented at or below cpu level");

   AST_HANDLER_ADDR: assert property (@(posedge clk) disable iff (srst) // RULE_20
      present.valid |->
      present.addr == ($past(altSelect) ? `ALT_BASE : `PRI_BASE) +
                      {16'h0000, present.vector, 1'b0})
      else $error("handler address does not match selected table");

   AST_PEND_LATCH: assert property (@(posedge clk) disable iff (srst) // RULE_10
      present.valid |-> pendVector == present.vector && pendLevel == present.level)
      else $error("pending vector register differs from presented request");
endmodule

// ===== hw/vic_params.svh
// offsets, field positions, reset values and vector constants of the controller
`ifndef VIC_PARAMS_SVH
`define VIC_PARAMS_SVH
`define OFS_CTRL_ONE  8'h00
`define OFS_CTRL_TWO  8'h04
`define OFS_PEND_VEC  8'h08
`define OFS_STATUS    8'h0C
`define OFS_CORE      8'h10
`define OFS_VEC_ADDR  8'h14
`define OFS_FLAG0     8'h20
`define OFS_ENABLE0   8'h30
`define OFS_PRIO0     8'h40
`define POS_NEST      15
`define POS_ALT       15
`define POS_IPL_LO    5
`define POS_CPU_PRIORITY_BIT_THREE      3
`define POS_TRAP_LO   1
`define POS_ILR_LO    8
`define RST_IPL       3'h0
`define RST_PRIO      3'h0
`define IPL_MAX       3'h7
`define VEC_OFFSET    7'h08
`define PRI_BASE      24'h000004
`define ALT_BASE      24'h000104
`define IRQ_EXT0      0
`define IRQ_EXT1      20
`define IRQ_EXT2      29
`define IRQ_MOTOR_PWM_UNIT_ONE_PER  57
`define IRQ_QEI_CMP   58
`define IRQ_MOTOR_PWM_UNIT_ONE_FLT  63
`define IRQ_MOTOR_PWM_UNIT_TWO_PER  73
`define IRQ_MOTOR_PWM_UNIT_TWO_FLT  74
`endif

// ===== hw/vic_pkg.sv
// types shared by the interrupt controller
package vic_pkg;
   typedef struct packed {
      logic       valid;
      logic [6:0] vector;
      logic [3:0] level;
      logic [23:0] addr;
   } irq_present_t;
   typedef struct packed {
      logic mathErr;
      logic addrErr;
      logic stackErr;
      logic oscFail;
   } trap_t;
endpackage

// ===== dv/cpu_core_model.sv
// cpu core model: takes presented requests, raises and ends traps, returns from handlers
module cpu_core_model
   import vic_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire irq_present_t present,
   input  wire logic         autoAck,
   input  wire logic [3:0]   ackDelay,
   output logic              cpuAck,
   output logic              cpuReturn,
   output logic [2:0]        returnLevel,
   output trap_t             trapEvent,
   output logic              trapReturn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] waitCnt;
   initial begin
      cpuAck = 1'b0;
      cpuReturn = 1'b0;
      returnLevel = 3'h0;
      trapEvent = '0;
      trapReturn = 1'b0;
      waitCnt = 4'h0;
   end
   // a slow core lets the request stand for ackDelay cycles before taking it
   always @(posedge clk) begin
      cpuAck <= 1'b0;
      waitCnt <= 4'h0;
      if (!srst && autoAck && present.valid && !cpuAck) begin
         if (waitCnt == ackDelay) cpuAck <= 1'b1;
         else waitCnt <= waitCnt + 4'h1;
      end
   end
   task automatic raiseTrap(input trap_t t);
      @(posedge clk);
      trapEvent <= t;
      @(posedge clk);
      trapEvent <= '0;
   endtask
   task automatic endTrap();
      @(posedge clk);
      trapReturn <= 1'b1;
      @(posedge clk);
      trapReturn <= 1'b0;
   endtask
   task automatic returnTo(input logic [2:0] l);
      @(posedge clk);
      returnLevel <= l;
      cpuReturn <= 1'b1;
      @(posedge clk);
      cpuReturn <= 1'b0;
   endtask
endmodule

// ===== dv/tb_top.sv
// self-checking bench of the vectored interrupt controller
`include "vic_params.svh"
module tb_top
   import vic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic pready, pslverr, rerr;
   logic [74:0] periphEvent = '0;
   logic [2:0]  extPin = 3'h0, returnLevel;
   logic pwmOnePeriod = 0, qeiCompare = 0, pwmOneFault = 0, pwmTwoPeriod = 0, pwmTwoFault = 0;
   logic cpuAck, cpuReturn, trapReturn, autoAck = 1'b0;
   logic [3:0]  ackDelay = 4'h0, cpuLevel;
   trap_t        trapEvent;
   irq_present_t present;
   int errors = 0, nCompared = 0;
   always #10 clk = ~clk;
   vectored_interrupt_priority_ctrl i_vectored_interrupt_priority_ctrl (.clk(clk), .srst(srst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .periphEvent(periphEvent),
      .extPin(extPin), .pwmOnePeriod(pwmOnePeriod), .qeiCompare(qeiCompare),
      .pwmOneFault(pwmOneFault), .pwmTwoPeriod(pwmTwoPeriod), .pwmTwoFault(pwmTwoFault),
      .trapEvent(trapEvent), .trapReturn(trapReturn), .cpuAck(cpuAck), .cpuReturn(cpuReturn),
      .returnLevel(returnLevel), .present(present), .cpuLevel(cpuLevel));
   cpu_core_model i_cpu_core_model (.clk(clk), .srst(srst), .present(present),
      .autoAck(autoAck), .ackDelay(ackDelay), .cpuAck(cpuAck), .cpuReturn(cpuReturn),
      .returnLevel(returnLevel), .trapEvent(trapEvent), .trapReturn(trapReturn));
   task automatic summarize();
      $display("compared %0d, mismatches %0d", nCompared, errors);
      if (errors == 0 && nCompared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; holds the request until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no cycle budget here: only the watchdog ends a stuck wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdata, exp);
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic drive(input int irq, input logic v);
      case (irq)
         57: pwmOnePeriod <= v;
         58: qeiCompare <= v;
         63: pwmOneFault <= v;
         73: pwmTwoPeriod <= v;
         74: pwmTwoFault <= v;
         default: periphEvent[irq] <= v;
      endcase
   endtask
   task automatic fire(input int irq);
      @(posedge clk);
      drive(irq, 1'b1);
      @(posedge clk);
      drive(irq, 1'b0);
   endtask
   // writing whole words clears the neighbours, so only one source is armed per word
   task automatic arm(input int irq, input logic [2:0] p);
      wr(8'(32'h30 + irq / 32 * 4), 32'h1 << (irq % 32));
      wr(8'(32'h40 + irq / 8 * 4), 32'(p) << (4 * (irq % 8)));
   endtask
   task automatic test_reset_map();
      logic [7:0] a;
      for (int i = 0; i < 22; i++) begin
         a = i < 6 ? 8'(i * 4) : i < 9 ? 8'(32'h20 + (i - 6) * 4) :
             i < 12 ? 8'(32'h30 + (i - 9) * 4) : 8'(32'h40 + (i - 12) * 4);
         apb(1'b0, a, 32'h0);
         check(32'(rerr), 32'h0);
         if (a != `OFS_VEC_ADDR) check(rdata, 32'h0);
      end
      wr(8'h18, 32'hFFFF_FFFF);
      check(32'(rerr), 32'h1);
      rd(8'h18, 32'h0);
   endtask
   task automatic test_routing();
      int irqs [5] = '{57, 58, 63, 73, 74};
      logic [23:0] prim [5] = '{24'h000086, 24'h000088, 24'h000092, 24'h0000A6, 24'h0000A8};
      foreach (irqs[i]) begin
         arm(irqs[i], 3'h1);
         fire(irqs[i]);
         settle();
         check(32'(present.valid), 32'h1);
         check(32'(present.vector), 32'(irqs[i] + 8));
         check(32'(present.addr), 32'(prim[i]));
         wr(`OFS_CTRL_TWO, 32'h8000);
         settle();
         check(32'(present.addr), 32'(prim[i]) + 32'h100);
         rd(`OFS_VEC_ADDR, 32'(prim[i]) + 32'h100);
         wr(`OFS_CTRL_TWO, 32'h0);
         wr(8'(32'h20 + irqs[i] / 32 * 4), 32'h0);
         settle();
         check(32'(present.valid), 32'h0);
      end
   endtask
   task automatic test_flag_enable();
      // all enables clear, so a pending flag must stay hidden
      wr(8'h34, 32'h0);
      wr(8'h38, 32'h0);
      wr(`OFS_PRIO0, 32'h0020_0000);
      fire(5);
      rd(`OFS_FLAG0, 32'h20);
      settle();
      check(32'(present.valid), 32'h0);
      wr(`OFS_ENABLE0, 32'h20);
      settle();
      check(32'(present.vector), 32'd13);
      wr(`OFS_FLAG0, 32'h0);
      rd(`OFS_FLAG0, 32'h0);
   endtask
   task automatic test_levels();
      wr(`OFS_ENABLE0, 32'h28);
      wr(`OFS_PRIO0, 32'h0040_4000);
      fire(5);
      fire(3);
      settle();
      check(32'(present.vector), 32'd11);
      rd(`OFS_PEND_VEC, 32'h040B);
      wr(`OFS_PRIO0, 32'h0060_4000);
      settle();
      check({present.vector, present.level}, {7'd13, 4'h6});
      wr(`OFS_STATUS, 32'hC0);
      settle();
      check(32'(present.valid), 32'h0);
      check(32'(cpuLevel), 32'h6);
      wr(`OFS_STATUS, 32'hA0);
      settle();
      check(32'(present.valid), 32'h1);
      wr(`OFS_PRIO0, 32'h0070_0000);
      wr(`OFS_STATUS, 32'hE0);
      settle();
      check(32'(present.valid), 32'h0);
      wr(`OFS_CTRL_ONE, 32'h8000);
      wr(`OFS_STATUS, 32'h0);
      rd(`OFS_STATUS, 32'hE0);
      rd(`OFS_CTRL_ONE, 32'h8000);
      wr(`OFS_CTRL_ONE, 32'h0);
      wr(`OFS_STATUS, 32'h0);
      rd(`OFS_STATUS, 32'h0);
   endtask
   task automatic test_trap();
      i_cpu_core_model.raiseTrap(4'b1001);
      settle();
      check(32'(present.valid), 32'h0);
      check(32'(cpuLevel), 32'h8);
      rd(`OFS_CTRL_ONE, 32'h12);
      wr(`OFS_CORE, 32'h0);
      rd(`OFS_CORE, 32'h8);
      i_cpu_core_model.endTrap();
      settle();
      rd(`OFS_CORE, 32'h0);
      check(32'(present.valid), 32'h1);
      wr(`OFS_CTRL_ONE, 32'h0);
      wr(`OFS_FLAG0, 32'h0);
   endtask
   task automatic test_ext_pins();
      @(posedge clk) extPin[0] <= 1'b1;
      rd(`OFS_FLAG0, 32'h1);
      wr(`OFS_CTRL_TWO, 32'h1);
      wr(`OFS_FLAG0, 32'h0);
      @(posedge clk) extPin[0] <= 1'b0;
      rd(`OFS_FLAG0, 32'h1);
      wr(`OFS_FLAG0, 32'h0);
      @(posedge clk) extPin[0] <= 1'b1;
      rd(`OFS_FLAG0, 32'h0);
      wr(`OFS_CTRL_TWO, 32'h0);
      @(posedge clk) extPin[2:1] <= 2'b11;
      rd(`OFS_FLAG0, 32'h2010_0000);
      wr(`OFS_FLAG0, 32'h0);
      wr(`OFS_CTRL_TWO, 32'h4);
      @(posedge clk) extPin[2:1] <= 2'b00;
      rd(`OFS_FLAG0, 32'h2000_0000);
      wr(`OFS_FLAG0, 32'h0);
      wr(`OFS_CTRL_TWO, 32'h0);
   endtask
   task automatic test_ack();
      arm(58, 3'h5);
      fire(58);
      ackDelay <= 4'h3;
      autoAck <= 1'b1;
      repeat (12) @(posedge clk);
      #1;
      check(32'(cpuLevel), 32'h5);
      check(32'(present.valid), 32'h0);
      autoAck <= 1'b0;
      i_cpu_core_model.returnTo(3'h2);
      settle();
      check(32'(cpuLevel), 32'h2);
      wr(`OFS_CTRL_ONE, 32'h8000);
      ackDelay <= 4'h0;
      autoAck <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      check(32'(cpuLevel), 32'h7);
      autoAck <= 1'b0;
   endtask
   initial begin
      #400000;
      errors++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      test_reset_map();
      test_routing();
      test_flag_enable();
      test_levels();
      test_trap();
      test_ext_pins();
      test_ack();
      summarize();
   end
endmodule
